// [include/pps_pkg.sv]
// constants and types for the point-of-load protection and sequencing block
// assumes a 200 MHz ref_clk and sampled measurements arriving as plain unsigned codes
package pps_pkg;
  // apb map, byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_THR = 12'h004;
  localparam logic [11:0] ADDR_SEQ = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00c;
  localparam logic [11:0] ADDR_CLR = 12'h010;
  // ctrl fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_TRKEN = 1;
  localparam int CTRL_LATCH = 2; // 5 bits: oc, ov, uv, ot, trk
  localparam int CTRL_PGLO = 7;
  localparam int CTRL_PHASE = 8; // 5 bits
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // thr fields
  localparam int THR_OC = 0; // 4 bits, 0..10
  localparam int THR_OV = 4; // 2 bits, 0..2
  localparam int THR_UV = 6; // 2 bits, 0..3
  localparam logic [31:0] THR_RST = 32'h0000_002a;
  // seq fields
  localparam int SEQ_TON = 0;   // 8 bits
  localparam int SEQ_TOFF = 8;  // 6 bits
  localparam int SEQ_RUP = 16;  // 3 bits
  localparam int SEQ_RDN = 20;  // 3 bits
  localparam logic [31:0] SEQ_RST = 32'h0000_0000;
  // measurement scaling: voltage in mV, current in percent of rated, temp in C
  localparam logic [15:0] OVP_FLOOR_MV = 16'h03e8;
  localparam logic [15:0] TRK_WIN_MV = 16'h00fa;
  localparam logic [7:0] OT_OFF_C = 8'h78;
  localparam logic [7:0] OT_ON_C = 8'h6e;
  localparam logic [7:0] OTW_HYST_C = 8'h03;
  localparam logic [7:0] OC_MAX_STEP = 8'h0a;
  localparam logic [7:0] PG_HI_PCT = 8'h6e;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int FILT_US = 6;
  localparam int FILT_CYC = FILT_US * CLK_MHZ;
  localparam int OT_MS = 2;
  localparam int MS_CYC = 1000 * CLK_MHZ;
  localparam int RETRY_MS = 130;
  localparam int FILT_W = 11;
  typedef enum logic [1:0] {F_OC, F_OV, F_UV, F_OT} pps_fault_t;
  typedef enum {S_OFF, S_DLYON, S_RAMPUP, S_ON, S_DLYOFF, S_RAMPDN, S_FAULT} pps_state_t;
endpackage

// [logic/pps_filter.sv]
// delay filter: output follows input once input held steady for a fixed count
// assumes inputs are synchronous to ref_clk
`timescale 1ns/10ps
module pps_filter import pps_pkg::*; #(
  parameter int CNT = FILT_CYC
) (
  input wire logic ref_clk, // clock
  input wire logic arst_n,  // async reset
  input wire logic rawIn,   // raw comparator level
  output logic filtOut      // filtered level
);
  logic [23:0] cnt_r;
  wire diff = rawIn != filtOut;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 24'h0;
      filtOut <= 1'b0;
    end else if (!diff) begin
      cnt_r <= 24'h0;
    end else if (cnt_r == 24'(CNT - 1)) begin
      cnt_r <= 24'h0;
      filtOut <= rawIn;
    end else begin
      cnt_r <= cnt_r + 24'h1;
    end
  end
endmodule

// [logic/pps_top.sv]
// protection, power good and sequencing core with an apb register file
// assumes vout/iout/temp samples arrive each cycle, synchronous to ref_clk
`timescale 1ns/10ps
module pps_top import pps_pkg::*; #(
  parameter int MS_CNT = MS_CYC
) (
  input wire logic ref_clk,        // 200 MHz clock
  input wire logic arst_n,         // async reset, active low
  input wire logic psel,           // apb select
  input wire logic penable,        // apb enable
  input wire logic pwrite,         // apb write
  input wire logic [11:0] paddr,   // apb address
  input wire logic [31:0] pwdata,  // apb write data
  output logic [31:0] prdata,      // apb read data
  output logic pready,             // apb ready
  output logic pslverr,            // apb error
  input wire logic [15:0] voutMv,  // sampled output voltage, mV
  input wire logic [15:0] vsetMv,  // voltage setpoint, mV
  input wire logic [15:0] vrefMv,  // ramp reference, mV
  input wire logic [7:0] ioutPct,  // output current, percent of rated
  input wire logic [7:0] tempC,    // controller temperature, C
  output logic outputOn,           // converter enable command
  output logic rampUp,             // reference rising
  output logic rampDown,           // reference falling
  output logic [2:0] rampRate,     // selected ramp rate code
  output logic [4:0] phaseCode,    // phase offset, 11.25 degree units
  output logic power_good_output,  // power good level
  output logic otWarn              // overtemperature warning
);
  logic [31:0] ctrl_r, thr_r, seq_r;
  logic [4:0] flt_r;
  logic otWarnRaw_r;
  pps_state_t st_r;
  logic [27:0] msCnt_r;
  logic [7:0] msLeft_r;
  logic [11:0] ms2_r;

  // apb slave, zero wait states
  wire apbAcc = psel & penable;
  wire wrCtrl = apbAcc & pwrite & (paddr == ADDR_CTRL);
  wire wrThr = apbAcc & pwrite & (paddr == ADDR_THR);
  wire wrSeq = apbAcc & pwrite & (paddr == ADDR_SEQ);
  wire wrClr = apbAcc & pwrite & (paddr == ADDR_CLR);
  wire mapped = paddr == ADDR_CTRL || paddr == ADDR_THR || paddr == ADDR_SEQ ||
    paddr == ADDR_STAT || paddr == ADDR_CLR;
  assign pready = 1'b1;
  assign pslverr = apbAcc & ~mapped;
  wire [31:0] statWord = {22'h0, 4'(st_r), otWarn, flt_r};
  assign prdata = (paddr == ADDR_CTRL) ? ctrl_r : (paddr == ADDR_THR) ? thr_r :
    (paddr == ADDR_SEQ) ? seq_r : (paddr == ADDR_STAT) ? statWord : 32'h0;

  // thresholds
  wire [3:0] ocSel = thr_r[THR_OC +: 4];
  wire [7:0] ocStep = (8'(ocSel) > OC_MAX_STEP) ? OC_MAX_STEP : 8'(ocSel);
  wire [7:0] ocPct = 8'd40 + 8'(ocStep * 8'd10);
  wire [1:0] ovSel = (thr_r[THR_OV +: 2] > 2'd2) ? 2'd2 : thr_r[THR_OV +: 2];
  wire [7:0] ovPct = 8'd110 + 8'(ovSel * 8'd10);
  wire [7:0] uvPct = 8'd75 + 8'(thr_r[THR_UV +: 2] * 8'd5);
  wire [7:0] pgLoPct = ctrl_r[CTRL_PGLO] ? 8'd95 : 8'd90;
  wire [23:0] vset100 = 24'(vsetMv);
  wire [23:0] vout100 = 24'(voutMv) * 24'd100;
  wire [23:0] ovRaw = vset100 * 24'(ovPct);
  wire [23:0] ovFloor = 24'(OVP_FLOOR_MV) * 24'd100;
  wire [23:0] ovLim = (ovRaw < ovFloor) ? ovFloor : ovRaw;
  wire running = st_r == S_RAMPUP || st_r == S_ON;
  wire ovRaw_c = running & (vout100 > ovLim);
  wire uvRaw_c = (st_r == S_ON) & (vout100 < vset100 * 24'(uvPct));
  wire ocRaw_c = running & (ioutPct > ocPct);
  wire [15:0] dv = (voutMv > vrefMv) ? voutMv - vrefMv : vrefMv - voutMv;
  wire trkRaw_c = ctrl_r[CTRL_TRKEN] & (st_r == S_RAMPUP) & (dv > TRK_WIN_MV);
  wire otHot = tempC >= OT_OFF_C;
  wire pgRaw_c = (vout100 >= vset100 * 24'(pgLoPct)) &
    (vout100 <= vset100 * 24'(PG_HI_PCT));
  wire otwRaw_c = otWarnRaw_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) otWarnRaw_r <= 1'b0;
    else if (tempC >= OT_OFF_C) otWarnRaw_r <= 1'b1;
    else if (tempC <= OT_OFF_C - OTW_HYST_C) otWarnRaw_r <= 1'b0;
  end

  logic ovF, uvF, ocF, trkF;
  pps_filter u_ov (.ref_clk(ref_clk), .arst_n(arst_n), .rawIn(ovRaw_c), .filtOut(ovF));
  pps_filter u_uv (.ref_clk(ref_clk), .arst_n(arst_n), .rawIn(uvRaw_c), .filtOut(uvF));
  pps_filter u_oc (.ref_clk(ref_clk), .arst_n(arst_n), .rawIn(ocRaw_c), .filtOut(ocF));
  pps_filter u_tk (.ref_clk(ref_clk), .arst_n(arst_n), .rawIn(trkRaw_c), .filtOut(trkF));
  pps_filter u_pg (.ref_clk(ref_clk), .arst_n(arst_n), .rawIn(pgRaw_c),
    .filtOut(power_good_output));
  pps_filter u_ow (.ref_clk(ref_clk), .arst_n(arst_n), .rawIn(otwRaw_c),
    .filtOut(otWarn));

  // millisecond tick and 2 ms overtemperature qualifier
  wire msTick = msCnt_r == 28'(MS_CNT - 1);
  wire otF = ms2_r == 12'(OT_MS);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) msCnt_r <= 28'h0;
    else msCnt_r <= msTick ? 28'h0 : msCnt_r + 28'h1;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) ms2_r <= 12'h0;
    else if (!otHot || !running) ms2_r <= 12'h0;
    else if (msTick && !otF) ms2_r <= ms2_r + 12'h1;
  end

  // fault capture; set wins over a software clear
  wire [4:0] newFlt = {trkF, otF, uvF, ovF, ocF};
  wire anyNew = |newFlt & running;
  wire latchHit = |(newFlt & ctrl_r[CTRL_LATCH +: 5]);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) flt_r <= 5'h0;
    else flt_r <= (flt_r & ~(wrClr ? pwdata[4:0] : 5'h0)) | (running ? newFlt : 5'h0);
  end

  // registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RST;
      thr_r <= THR_RST;
      seq_r <= SEQ_RST;
    end else begin
      if (wrCtrl) ctrl_r <= {19'h0, pwdata[12:0]};
      if (wrThr) thr_r <= {24'h0, pwdata[7:0]};
      if (wrSeq) seq_r <= {9'h0, pwdata[22:20], 1'b0, pwdata[18:16], 2'h0, pwdata[13:0]};
    end
  end

  // sequencer
  logic latched_r;
  wire [15:0] dn = 16'd20;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= S_OFF;
      msLeft_r <= 8'h0;
      latched_r <= 1'b0;
    end else begin
      if (wrClr && pwdata[8]) latched_r <= 1'b0;
      unique case (st_r)
        S_OFF: if (ctrl_r[CTRL_EN] && !latched_r && tempC <= OT_ON_C) begin
          st_r <= S_DLYON;
          msLeft_r <= seq_r[SEQ_TON +: 8];
        end
        S_DLYON: if (!ctrl_r[CTRL_EN]) st_r <= S_OFF;
          else if (msLeft_r == 8'h0) st_r <= S_RAMPUP;
          else if (msTick) msLeft_r <= msLeft_r - 8'h1;
        S_RAMPUP, S_ON: if (anyNew) begin
            st_r <= S_FAULT;
            msLeft_r <= 8'(RETRY_MS);
            if (latchHit) latched_r <= 1'b1;
          end else if (!ctrl_r[CTRL_EN]) begin
            st_r <= S_DLYOFF;
            msLeft_r <= {2'h0, seq_r[SEQ_TOFF +: 6]};
          end else if (st_r == S_RAMPUP && vrefMv >= vsetMv) st_r <= S_ON;
        S_DLYOFF: if (msLeft_r == 8'h0) st_r <= S_RAMPDN;
          else if (msTick) msLeft_r <= msLeft_r - 8'h1;
        S_RAMPDN: if (vrefMv < dn) st_r <= S_OFF;
        S_FAULT: if (latched_r) st_r <= S_OFF;
          else if (msLeft_r == 8'h0) st_r <= S_OFF;
          else if (msTick) msLeft_r <= msLeft_r - 8'h1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      outputOn <= 1'b0;
      rampUp <= 1'b0;
      rampDown <= 1'b0;
      rampRate <= 3'h0;
      phaseCode <= 5'h0;
    end else begin
      outputOn <= st_r == S_RAMPUP || st_r == S_ON || st_r == S_DLYOFF || st_r == S_RAMPDN;
      rampUp <= st_r == S_RAMPUP;
      rampDown <= st_r == S_RAMPDN;
      rampRate <= (st_r == S_RAMPDN) ? seq_r[SEQ_RDN +: 3] : seq_r[SEQ_RUP +: 3];
      phaseCode <= ctrl_r[CTRL_PHASE +: 5];
    end
  end

  sequence s_trip;
    running && anyNew;
  endsequence
  sequence s_stop;
    (st_r == S_FAULT) ##1 !outputOn;
  endsequence
  property p_trip_off;
    @(posedge ref_clk) disable iff (!arst_n) s_trip |=> s_stop;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("fault did not stop output");

  property p_ov_floor;
    @(posedge ref_clk) disable iff (!arst_n) (vout100 <= ovFloor) |-> !ovRaw_c;
  endproperty
  a_ov_floor: assert property (p_ov_floor) else $error("ov limit under floor");

  property p_latch_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      (latched_r && st_r == S_OFF && !wrClr) |=> st_r == S_OFF;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched fault restarted");

  property p_trk_gate;
    @(posedge ref_clk) disable iff (!arst_n) trkRaw_c |-> st_r == S_RAMPUP;
  endproperty
  a_trk_gate: assert property (p_trk_gate) else $error("tracking active off ramp");

  property p_oc_range;
    @(posedge ref_clk) disable iff (!arst_n) ocPct >= 8'd40 && ocPct <= 8'd140;
  endproperty
  a_oc_range: assert property (p_oc_range) else $error("oc threshold out of range");

  property p_pg_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      $changed(power_good_output) |-> $past(pgRaw_c) == power_good_output;
  endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("power good moved wrongly");

  property p_ot_restart;
    @(posedge ref_clk) disable iff (!arst_n)
      (st_r == S_OFF && tempC > OT_ON_C) |=> st_r != S_DLYON;
  endproperty
  a_ot_restart: assert property (p_ot_restart) else $error("restart while hot");

  property p_warn_set;
    @(posedge ref_clk) disable iff (!arst_n) $rose(otWarn) |-> $past(otwRaw_c);
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning without cause");
endmodule

// [tb/pps_plant_model.sv]
// behavioural converter plant: reference ramp and output voltage
// assumes rampUp, rampDown and outputOn are registered levels on ref_clk
`timescale 1ns/10ps
module pps_plant_model (
  input wire logic ref_clk,        // clock
  input wire logic arst_n,         // async reset
  input wire logic outputOn,       // converter enable
  input wire logic rampUp,         // reference rising
  input wire logic rampDown,       // reference falling
  input wire logic [15:0] vsetMv,  // setpoint
  input wire logic [15:0] voffMv,  // disturbance from the bench
  output logic [15:0] vrefMv,      // ramp reference
  output logic [15:0] voutMv       // output voltage
);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      vrefMv <= 16'h0000;
    end else if (rampUp && vrefMv < vsetMv) begin
      vrefMv <= vrefMv + 16'h0004;
    end else if (rampDown && vrefMv > 16'h0003) begin
      vrefMv <= vrefMv - 16'h0004;
    end
  end
  // a stopped stage discharges, so only the disturbance remains
  assign voutMv = outputOn ? vrefMv + voffMv : voffMv;
endmodule

// [tb/tb.sv]
// self-checking bench for the protection and sequencing core
// assumes a zero-wait apb slave and a short millisecond count
`timescale 1ns/10ps
module tb;
  import pps_pkg::*;
  localparam int MSC = 20;
  localparam logic [32:0] ALL = 33'h1ffffffff;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, outputOn, rampUp, rampDown, power_good_output, otWarn;
  logic [15:0] voutMv, vrefMv;
  logic [15:0] vsetMv = 16'h03e8;
  logic [15:0] voffMv = 16'h0000;
  logic [7:0] ioutPct = 8'h32;
  logic [7:0] tempC = 8'h19;
  logic [2:0] rampRate, rr;
  logic [4:0] phaseCode, ph;
  logic [65:0] expQ[$];
  logic [65:0] q;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 32'hbb3e;
  pps_top #(.MS_CNT(MSC)) uut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .voutMv(voutMv), .vsetMv(vsetMv), .vrefMv(vrefMv),
    .ioutPct(ioutPct), .tempC(tempC), .outputOn(outputOn), .rampUp(rampUp),
    .rampDown(rampDown), .rampRate(rampRate), .phaseCode(phaseCode),
    .power_good_output(power_good_output), .otWarn(otWarn));
  pps_plant_model plant (.ref_clk(ref_clk), .arst_n(arst_n), .outputOn(outputOn),
    .rampUp(rampUp), .rampDown(rampDown), .vsetMv(vsetMv), .voffMv(voffMv),
    .vrefMv(vrefMv), .voutMv(voutMv));
  always #2.5 ref_clk = ~ref_clk;
  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    expQ.push_back({m, e});
    apb(1'b0, a, 32'h0);
  endtask
  // read data is taken at the access edge, before that edge's updates land
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      q = expQ.pop_front();
      chk({pslverr, prdata} & q[65:33], q[32:0]);
    end
  end
  function automatic logic lvl(input int i);
    logic [4:0] lv;
    lv = {rampUp, rampDown, otWarn, power_good_output, outputOn};
    return lv[i];
  endfunction
  // level must not be v after lo cycles, then reach v within hi cycles
  task automatic waitv(input int i, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    repeat (lo) @(posedge ref_clk);
    if (lo > 0) chk({32'h0, lvl(i)}, {32'h0, ~v});
    while (lvl(i) !== v && n < hi) begin
      @(posedge ref_clk);
      n++;
    end
    if (hi > 0) chk({32'h0, lvl(i)}, {32'h0, v});
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(ADDR_CTRL, {1'b0, 32'h0}, ALL);
    rd(ADDR_THR, {1'b0, 32'h2a}, ALL);
    rd(ADDR_SEQ, {1'b0, 32'h0}, ALL);
    rd(12'h014, {1'b1, 32'h0}, ALL);
    ph = 5'($random(seed));
    rr = 3'(($random(seed) & 32'h7fff_ffff) % 7);
    apb(1'b1, ADDR_SEQ, {9'h0, rr, 1'b0, rr, 16'h0002});
    rd(ADDR_SEQ, {1'b0, 9'h0, rr, 1'b0, rr, 16'h0002}, ALL);
    apb(1'b1, ADDR_CTRL, {19'h0, ph, 8'h01});
    waitv(0, 1'b1, 20, 40);
    chk({30'h0, rampRate}, {30'h0, rr});
    chk({28'h0, phaseCode}, {28'h0, ph});
    waitv(1, 1'b1, 0, 1800);
    voffMv <= 16'h00c8;
    waitv(1, 1'b0, 1150, 150);
    chk({32'h0, outputOn}, 33'h1);
    voffMv <= 16'hffba;
    waitv(1, 1'b1, 1150, 150);
    waitv(1, 1'b0, 1300, 0);
    apb(1'b1, ADDR_CTRL, {19'h0, ph, 8'h81});
    waitv(1, 1'b0, 1150, 150);
    voffMv <= 16'h015e;
    waitv(0, 1'b0, 1150, 150);
    voffMv <= 16'h0000;
    rd(ADDR_STAT, {1'b0, 32'h2}, 33'h2);
    waitv(0, 1'b1, 2500, 400);
    apb(1'b1, ADDR_CTRL, {19'h0, ph, 8'h85});
    ioutPct <= 8'h82;
    waitv(0, 1'b0, 1500, 0);
    ioutPct <= 8'h96;
    waitv(0, 1'b0, 0, 1500);
    ioutPct <= 8'h32;
    waitv(0, 1'b1, 3000, 0);
    apb(1'b1, ADDR_CLR, 32'h0000_011f);
    waitv(0, 1'b1, 0, 300);
    tempC <= 8'h79;
    waitv(0, 1'b0, 20, 30);
    waitv(2, 1'b1, 1100, 150);
    rd(ADDR_STAT, {1'b0, 32'h20}, 33'h20);
    tempC <= 8'h76;
    waitv(2, 1'b0, 1300, 0);
    tempC <= 8'h73;
    waitv(0, 1'b1, 3000, 0);
    waitv(2, 1'b0, 0, 10);
    tempC <= 8'h6e;
    waitv(0, 1'b1, 0, 3000);
    vsetMv <= 16'h0320;
    apb(1'b1, ADDR_THR, 32'h0000_000a);
    voffMv <= 16'hffd8;
    waitv(0, 1'b0, 1500, 0);
    apb(1'b1, ADDR_SEQ, {9'h0, 3'(3'd6 - rr), 1'b0, rr, 16'h0200});
    apb(1'b1, ADDR_CTRL, {19'h0, ph, 8'h84});
    waitv(3, 1'b1, 20, 30);
    chk({30'h0, rampRate}, {30'h0, 3'(3'd6 - rr)});
    waitv(0, 1'b0, 200, 100);
    vsetMv <= 16'h1770;
    voffMv <= 16'h012c;
    apb(1'b1, ADDR_CTRL, {19'h0, ph, 8'h03});
    waitv(4, 1'b1, 0, 10);
    waitv(0, 1'b0, 1140, 150);
    rd(ADDR_STAT, {1'b0, 32'h10}, 33'h10);
    end_sim();
  end
endmodule
